// ==== design/tcd_consts.svh ====
// Purpose: constants for the per-channel control decoder
// Assumes: 4 streams of 32 channels, 16-bit connection words
// Notes: definitions only
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH
`define TCD_STREAMS 3'h4
`define TCD_LAST_STREAM 2'h3
`define TCD_BIT_LOOPBACK 15
`define TCD_BIT_DELAY_MODE 14
`define TCD_BIT_PROC_CHANNEL 13
`define TCD_BIT_CONTROL_OUT 12
`define TCD_BIT_OUT_ENABLE 11
`define TCD_SRC_STREAM_HI 8
`define TCD_SRC_STREAM_LO 7
`define TCD_SRC_CHANNEL_HI 4
`define TCD_PROC_BYTE_HI 7
`define TCD_WORD_RESET 16'h0000
`define TCD_ADDR_RESET 7'h00
`define TCD_BYTE_RESET 8'h00
`endif

// ==== design/tcd_pkg.sv ====
// Purpose: types shared by the decoder, its partner model and the bench
// Assumes: nothing beyond the constants header
// Notes: record fields travel from decoder to transmit side
package tcd_pkg;
  // one decoded output channel
  typedef struct packed {
    logic [1:0] stream;       // output stream
    logic [4:0] channel;      // output channel
    logic loopback;           // receive side takes transmit byte
    logic const_delay;        // 1 constant, 0 variable throughput delay
    logic proc_channel;       // payload is sent instead of switched data
    logic out_enable;         // 0 puts transmit driver in high impedance
    logic [7:0] payload;      // lower byte of the word
    logic [1:0] src_stream;   // switched input stream
    logic [4:0] src_channel;  // switched input channel
  } tcd_rec_t;
  // fetch sequencer states, one-hot
  typedef enum logic [3:0] {
    TCD_IDLE  = 4'h1,
    TCD_READ  = 4'h2,
    TCD_LATCH = 4'h4,
    TCD_PUSH  = 4'h8
  } tcd_state_t;
endpackage

// ==== design/tcd_buffer.sv ====
// Purpose: two-entry buffer between decoder and transmit side
// Assumes: single clock, asynchronous active-low reset
// Notes: out_valid_out and out_data_out come straight from flops; in_ready_out is the inverted tail flag
`timescale 1ns/1ps
module tcd_buffer #(
  parameter int WIDTH = 26
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic tail_valid_reg; // second entry occupied
  logic [WIDTH-1:0] tail_reg;
  logic in_fire;
  logic out_fire;

  assign in_fire = in_valid_in && !tail_valid_reg;
  assign out_fire = out_valid_out && out_ready_in;
  assign in_ready_out = !tail_valid_reg;

  // head entry, drives the output side
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (!out_valid_out || out_fire) begin
      // head free: take tail first, then fresh input
      if (tail_valid_reg) begin
        out_valid_out <= 1'b1;
        out_data_out <= tail_reg;
      end else begin
        out_valid_out <= in_fire;
        if (in_fire) begin
          out_data_out <= in_data_in;
        end
      end
    end
  end

  // tail entry, fills when the head is stalled
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tail_valid_reg <= 1'b0;
      tail_reg <= '0;
    end else if (tail_valid_reg) begin
      if (!out_valid_out || out_fire) begin
        // moves to head; input is refused meanwhile
        tail_valid_reg <= 1'b0;
      end
    end else if (in_fire && out_valid_out && !out_ready_in) begin
      tail_valid_reg <= 1'b1;
      tail_reg <= in_data_in;
    end
  end
endmodule

// ==== design/tcd_decoder.sv ====
// Purpose: per-channel control decode of connection words
// Assumes: timing unit pulses slot_strobe_in at each channel slot
// Notes: connection memory read data is valid one cycle after the enable
`timescale 1ns/1ps
`include "tcd_consts.svh"
module tcd_decoder (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic slot_strobe_in,          // start of a channel slot
  input wire logic [4:0] channel_in,        // channel of the current slot
  input wire logic ctrl_shift_in,           // advance pin to next stream's bit
  output logic cm_rd_en_out,                // connection memory read
  output logic [6:0] cm_rd_addr_out,        // {stream, channel}
  input wire logic [15:0] cm_rd_data_in,    // word, one cycle after read
  output logic rec_valid_out,               // decoded record available
  input wire logic rec_ready_in,            // transmit side takes record
  output tcd_pkg::tcd_rec_t rec_out,        // decoded record
  output logic control_channel_out,         // control-channel pin
  input wire logic rx_valid_in,             // received byte strobe
  input wire logic [6:0] rx_addr_in,        // {stream, channel} received
  input wire logic [7:0] rx_byte_in,        // byte from the receive pin
  input wire logic [7:0] tx_loop_byte_in,   // byte sent on same stream/channel
  output logic dm_wr_en_out,                // data memory write
  output logic [6:0] dm_wr_addr_out,
  output logic [7:0] dm_wr_data_out
);
  tcd_pkg::tcd_state_t state_reg;
  logic [1:0] stream_reg;       // stream being fetched
  logic [4:0] chan_reg;         // channel being fetched
  logic [15:0] word_reg;        // latched connection word
  logic [3:0] ctrl_collect_reg; // control bits of next channel
  logic [3:0] ctrl_shift_reg;   // control bits being presented
  logic [127:0] loop_map_reg;   // loopback bit per stream/channel
  tcd_pkg::tcd_rec_t push_rec;
  logic push_ready;
  logic push_valid;
  logic push_fire;

  assign push_valid = (state_reg == tcd_pkg::TCD_PUSH);
  assign push_fire = push_valid && push_ready;

  // decode the latched word into a record
  always_comb begin
    push_rec.stream = stream_reg;
    push_rec.channel = chan_reg;
    push_rec.loopback = word_reg[`TCD_BIT_LOOPBACK];
    push_rec.const_delay = word_reg[`TCD_BIT_DELAY_MODE];
    push_rec.proc_channel = word_reg[`TCD_BIT_PROC_CHANNEL];
    push_rec.out_enable = word_reg[`TCD_BIT_OUT_ENABLE];
    push_rec.payload = word_reg[`TCD_PROC_BYTE_HI:0];
    push_rec.src_stream = word_reg[`TCD_SRC_STREAM_HI:`TCD_SRC_STREAM_LO];
    push_rec.src_channel = word_reg[`TCD_SRC_CHANNEL_HI:0];
  end

  // fetch sequencer: four words of next channel per slot
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= tcd_pkg::TCD_IDLE;
      stream_reg <= 2'h0;
      chan_reg <= 5'h00;
      cm_rd_en_out <= 1'b0;
      cm_rd_addr_out <= `TCD_ADDR_RESET;
    end else begin
      case (state_reg)
        tcd_pkg::TCD_IDLE: begin
          // one fetch per slot, so each word once per frame
          if (slot_strobe_in) begin
            stream_reg <= 2'h0;
            chan_reg <= channel_in + 5'h01;
            cm_rd_en_out <= 1'b1;
            cm_rd_addr_out <= {2'h0, channel_in + 5'h01};
            state_reg <= tcd_pkg::TCD_READ;
          end
        end
        tcd_pkg::TCD_READ: begin
          // memory samples address on this edge
          cm_rd_en_out <= 1'b0;
          state_reg <= tcd_pkg::TCD_LATCH;
        end
        tcd_pkg::TCD_LATCH: begin
          state_reg <= tcd_pkg::TCD_PUSH;
        end
        tcd_pkg::TCD_PUSH: begin
          // wait here while the buffer is full
          if (push_ready) begin
            if (stream_reg == `TCD_LAST_STREAM) begin
              state_reg <= tcd_pkg::TCD_IDLE;
            end else begin
              stream_reg <= stream_reg + 2'h1;
              cm_rd_en_out <= 1'b1;
              cm_rd_addr_out <= {stream_reg + 2'h1, chan_reg};
              state_reg <= tcd_pkg::TCD_READ;
            end
          end
        end
        default: begin
          state_reg <= tcd_pkg::TCD_IDLE;
          cm_rd_en_out <= 1'b0;
        end
      endcase
    end
  end

  // capture the word the cycle it arrives
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_reg <= `TCD_WORD_RESET;
    end else if (state_reg == tcd_pkg::TCD_LATCH) begin
      word_reg <= cm_rd_data_in;
    end
  end

  // control-channel bits: collected for next channel, shifted stream0 first
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_collect_reg <= 4'h0;
      ctrl_shift_reg <= 4'h0;
      control_channel_out <= 1'b0;
    end else begin
      // collect every accepted word's control bit
      if (push_fire) begin
        ctrl_collect_reg[stream_reg] <= word_reg[`TCD_BIT_CONTROL_OUT];
      end
      // load wins over a shift only on the last-stream accept
      if (push_fire && stream_reg == `TCD_LAST_STREAM) begin
        // present one channel ahead of the channel itself
        ctrl_shift_reg <= {1'b0, word_reg[`TCD_BIT_CONTROL_OUT], ctrl_collect_reg[2:1]};
        control_channel_out <= ctrl_collect_reg[0];
      end else if (ctrl_shift_in) begin
        // shifts stay honoured while earlier streams are accepted
        control_channel_out <= ctrl_shift_reg[0];
        ctrl_shift_reg <= {1'b0, ctrl_shift_reg[3:1]};
      end
    end
  end

  // loopback map, refreshed as each word is decoded
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      loop_map_reg <= '0;
    end else if (push_fire) begin
      loop_map_reg[{stream_reg, chan_reg}] <= word_reg[`TCD_BIT_LOOPBACK];
    end
  end

  // receive path into data memory, loopback chooses transmit byte
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dm_wr_en_out <= 1'b0;
      dm_wr_addr_out <= `TCD_ADDR_RESET;
      dm_wr_data_out <= `TCD_BYTE_RESET;
    end else begin
      dm_wr_en_out <= rx_valid_in;
      if (rx_valid_in) begin
        dm_wr_addr_out <= rx_addr_in;
        dm_wr_data_out <= loop_map_reg[rx_addr_in] ? tx_loop_byte_in : rx_byte_in;
      end
    end
  end

  // two-entry buffer towards the transmit side
  tcd_buffer #(.WIDTH($bits(tcd_pkg::tcd_rec_t))) i_tcd_buffer (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_rec),
    .out_valid_out(rec_valid_out),
    .out_ready_in(rec_ready_in),
    .out_data_out(rec_out)
  );

  // decode, receive path and fetch sequencing checks
  chk_loop_mux: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    rx_valid_in && loop_map_reg[rx_addr_in] |=> dm_wr_en_out && dm_wr_data_out == $past(tx_loop_byte_in))
    else $error("loopback byte not taken from transmit");
  chk_delay_mode: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_reg == tcd_pkg::TCD_LATCH |=> push_rec.const_delay == $past(cm_rd_data_in[14]))
    else $error("delay mode bit misdecoded");
  chk_proc_byte: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_reg == tcd_pkg::TCD_LATCH && cm_rd_data_in[13]
    |=> push_rec.proc_channel && push_rec.payload == $past(cm_rd_data_in[7:0]))
    else $error("processor byte wrong");
  chk_switch_addr: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_reg == tcd_pkg::TCD_LATCH && !cm_rd_data_in[13]
    |=> !push_rec.proc_channel && push_rec.src_channel == $past(cm_rd_data_in[4:0]))
    else $error("switched channel address wrong");
  chk_src_stream: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_reg == tcd_pkg::TCD_LATCH |=> push_rec.src_stream == $past(cm_rd_data_in[8:7]))
    else $error("source stream wrong");
  chk_ctrl_first: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    push_fire && stream_reg == 2'h3 |=> control_channel_out == $past(ctrl_collect_reg[0]))
    else $error("stream0 control bit not first");
  chk_oe_bit: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_reg == tcd_pkg::TCD_LATCH |=> push_rec.out_enable == $past(cm_rd_data_in[11]))
    else $error("output enable misdecoded");
  chk_fetch_next: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    state_reg == tcd_pkg::TCD_IDLE && slot_strobe_in
    |=> cm_rd_en_out && cm_rd_addr_out == {2'h0, $past(channel_in) + 5'h01} ##1 !cm_rd_en_out ##1 push_valid)
    else $error("slot fetch of next channel wrong");
  chk_ctrl_load: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    push_fire |=> ctrl_collect_reg[$past(stream_reg)] == $past(word_reg[`TCD_BIT_CONTROL_OUT]))
    else $error("control bit not collected");
  chk_ctrl_shift: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ctrl_shift_in && !(push_fire && stream_reg == 2'h3) |=> control_channel_out == $past(ctrl_shift_reg[0]))
    else $error("control pin did not advance");
  chk_rx_plain: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    rx_valid_in && !loop_map_reg[rx_addr_in] |=> dm_wr_en_out && dm_wr_data_out == $past(rx_byte_in))
    else $error("receive byte not taken from pin");
  chk_loop_map: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    push_fire |=> loop_map_reg[{$past(stream_reg), $past(chan_reg)}] == $past(word_reg[`TCD_BIT_LOOPBACK]))
    else $error("loopback map not refreshed");
  // a read strobe lasts one cycle, so each word is fetched once
  chk_rd_pulse: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    cm_rd_en_out |=> !cm_rd_en_out)
    else $error("read strobe longer than one cycle");
  chk_push_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    push_valid && !push_ready |=> push_valid && $stable(word_reg))
    else $error("stalled record not held");
endmodule

// ==== sim/tcd_partner.sv ====
// Purpose: connection memory and transmit-side model facing the decoder
// Assumes: read word is wanted in the cycle after a read enable
// Notes: the bench loads words through mem and reads taken records from got
`timescale 1ns/1ps
module tcd_partner (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic stall_in,                 // transmit side refuses records
  input wire logic cm_rd_en_in,              // read strobe from decoder
  input wire logic [6:0] cm_rd_addr_in,      // {stream, channel}
  output logic [15:0] cm_rd_data_out,        // word one cycle after read
  input wire logic rec_valid_in,             // record offered
  output logic rec_ready_out,                // record taken when high
  input wire tcd_pkg::tcd_rec_t rec_in       // decoded record
);
  logic [15:0] mem [0:127];                  // words, unused bits kept zero
  tcd_pkg::tcd_rec_t got [$];                // records taken, in order
  // read port: word after enable, then scrambled so stale data never passes
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cm_rd_data_out <= 16'h5a5a;
    end else if (cm_rd_en_in) begin
      cm_rd_data_out <= mem[cm_rd_addr_in];
    end else begin
      cm_rd_data_out <= ~cm_rd_data_out;
    end
  end
  // transmit side stalls on request
  assign rec_ready_out = !stall_in;
  // collect each accepted record
  always @(posedge clock_in) begin
    if (rst_b_in && rec_valid_in && rec_ready_out) begin
      got.push_back(rec_in);
    end
  end
endmodule

// ==== sim/tb_tcd_decoder.sv ====
// Purpose: self-checking bench for the per-channel control decoder
// Assumes: delay offsets of looped streams are zero outside this block
// Notes: no random stimulus; expected records, control bits and receive bytes come from the loaded words
`timescale 1ns/1ps
module tb_tcd_decoder;
  logic clock_in, rst_b_in, slot_strobe_in, ctrl_shift_in, stall, rx_valid_in;
  logic [4:0] channel_in;
  logic [6:0] rx_addr_in, cm_rd_addr, dm_wr_addr;
  logic [7:0] rx_byte_in, tx_loop_byte_in, dm_wr_data;
  logic cm_rd_en, rec_valid, rec_ready, ctrl_pin, dm_wr_en;
  logic [15:0] cm_rd_data;
  tcd_pkg::tcd_rec_t rec;
  int fail_count = 0;
  int cmp_count = 0;
  logic [15:0] words [0:3];                  // words of streams 0..3
  tcd_decoder i_tcd_decoder (.clock_in(clock_in), .rst_b_in(rst_b_in), .slot_strobe_in(slot_strobe_in),
    .channel_in(channel_in), .ctrl_shift_in(ctrl_shift_in), .cm_rd_en_out(cm_rd_en), .cm_rd_addr_out(cm_rd_addr),
    .cm_rd_data_in(cm_rd_data), .rec_valid_out(rec_valid), .rec_ready_in(rec_ready), .rec_out(rec),
    .control_channel_out(ctrl_pin), .rx_valid_in(rx_valid_in), .rx_addr_in(rx_addr_in), .rx_byte_in(rx_byte_in),
    .tx_loop_byte_in(tx_loop_byte_in), .dm_wr_en_out(dm_wr_en), .dm_wr_addr_out(dm_wr_addr),
    .dm_wr_data_out(dm_wr_data));
  tcd_partner i_tcd_partner (.clock_in(clock_in), .rst_b_in(rst_b_in), .stall_in(stall), .cm_rd_en_in(cm_rd_en),
    .cm_rd_addr_in(cm_rd_addr), .cm_rd_data_out(cm_rd_data), .rec_valid_in(rec_valid), .rec_ready_out(rec_ready),
    .rec_in(rec));
  // 25 mhz clock
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // compare and count
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // expected record from a word
  function automatic tcd_pkg::tcd_rec_t exp_rec(input logic [1:0] s, input logic [4:0] c, input logic [15:0] w);
    exp_rec = {s, c, w[15], w[14], w[13], w[11], w[7:0], w[8:7], w[4:0]};
  endfunction
  // one slot: fetch, stall, control pin, records, receive path
  task automatic run_slot(input logic [4:0] ch, input int hold);
    logic [4:0] nxt;
    logic [7:0] exp_byte;
    int n;
    nxt = ch + 5'h01;
    i_tcd_partner.got.delete();
    for (int s = 0; s < 4; s++) i_tcd_partner.mem[{s[1:0], nxt}] = words[s];
    stall <= (hold > 0);
    channel_in <= ch;
    slot_strobe_in <= 1'b1;
    @(posedge clock_in);
    slot_strobe_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    slot_strobe_in <= 1'b1;                  // mid-fetch strobe, must be ignored
    @(posedge clock_in);
    slot_strobe_in <= 1'b0;
    repeat (hold) @(posedge clock_in);
    #1;
    if (hold > 0) begin
      check({25'h0, rec_valid}, 26'h1);
      check(26'(i_tcd_partner.got.size()), 26'h0);
    end
    stall <= 1'b0;
    n = 0;
    while (i_tcd_partner.got.size() < 4 && n < 100) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    check({25'h0, ctrl_pin}, {25'h0, words[0][12]});
    for (int s = 1; s < 4; s++) begin
      ctrl_shift_in <= 1'b1;
      @(posedge clock_in);
      ctrl_shift_in <= 1'b0;
      #1;
      check({25'h0, ctrl_pin}, {25'h0, words[s][12]});
    end
    repeat (10) @(posedge clock_in);
    check(26'(i_tcd_partner.got.size()), 26'h4);
    for (int s = 0; s < 4 && s < i_tcd_partner.got.size(); s++) begin
      check(i_tcd_partner.got[s], exp_rec(s[1:0], nxt, words[s]));
    end
    // receive back to back on every stream of the channel
    for (int s = 0; s < 4; s++) begin
      rx_valid_in <= 1'b1;
      rx_addr_in <= {s[1:0], nxt};
      rx_byte_in <= 8'h30 + s[7:0];
      tx_loop_byte_in <= 8'hc0 + s[7:0];
      exp_byte = words[s][15] ? 8'hc0 + s[7:0] : 8'h30 + s[7:0];
      @(posedge clock_in);
      #1;
      check({10'h0, dm_wr_en, dm_wr_addr, dm_wr_data}, {10'h0, 1'b1, s[1:0], nxt, exp_byte});
    end
    rx_valid_in <= 1'b0;
    @(posedge clock_in);
  endtask
  // main sequence; looped streams have zero delay offset elsewhere
  initial begin
    rst_b_in = 1'b0;
    slot_strobe_in = 1'b0;
    ctrl_shift_in = 1'b0;
    stall = 1'b0;
    rx_valid_in = 1'b0;
    channel_in = 5'h00;
    rx_addr_in = 7'h00;
    rx_byte_in = 8'h00;
    tx_loop_byte_in = 8'h00;
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    #1;
    check({22'h0, cm_rd_en, rec_valid, ctrl_pin, dm_wr_en}, 26'h0);
    words = '{16'h999f, 16'h688a, 16'h0105, 16'hd090};
    run_slot(5'h04, 12);
    words = '{16'h0105, 16'hd090, 16'h999f, 16'h688a};
    run_slot(5'h1f, 0);                      // wraps to channel 0
    wrap_up();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge clock_in);
    fail_count++;
    wrap_up();
  end
endmodule
